// ==== verilog/sar_adc_control.sv ====
// Purpose: APB control, result registers and clocking of a 10-bit SAR converter
// Assumes: APB master on sys_clk; analog front end inputs are asynchronous
// Notes:   zero-wait APB with a registered pready, no extra access cycle
//          comparator answers settle only at the quarter-rate converter clock
//          five analog inputs share one sample capacitor through the mux
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "adc_defs.svh"

module sar_adc_control #(
    parameter int ADDR_W        = 12,
    parameter int APPROX_CYCLES = `APPROX_CYCLES,
    parameter int SAMPLE_TICKS  = `SAMPLE_TICKS
) (
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst,

    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,

    // power management
    input  wire logic                halt_mode,

    // analog front end, asynchronous
    input  wire logic                comp_above,
    input  wire logic [1:0]          comp_fine,
    input  wire logic                over_range,
    input  wire logic                under_range,

    // analog controls
    output logic                     converter_power,
    output logic [2:0]               input_channel_select,
    output logic                     sample_connect,
    output logic [`RESULT_BITS-1:0]  dac_code
);
    localparam int SYNC_W = 5;

    // a register index times four needs ten address bits
    if (ADDR_W < 10 || ADDR_W > 32) begin
        $error("sar_adc_control: unsupported address width");
    end
    // the two low result bits come from the fine comparator, not from trials
    if (`RESULT_BITS - APPROX_CYCLES != 2) begin
        $error("sar_adc_control: unsupported approximation count");
    end
    // the engine counts sample ticks in four bits
    if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 15) begin
        $error("sar_adc_control: unsupported sample length");
    end

    // byte address of a register index
    function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [7:0] index);
        hits = (addr == ADDR_W'({index, 2'b00}));
    endfunction

    // ---------------------------------------------------------------
    // synchronisers for the analog comparator outputs
    // ---------------------------------------------------------------
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;

    // every comparator output changes with no relation to sys_clk
    assign raw_in = {comp_above, comp_fine, over_range, under_range};

    // limitation: an answer reaches the engine two cycles after the trial
    // code moves; at the full and half rates the engine reads a stale one

    for (genvar g = 0; g < SYNC_W; g++) begin : sync_gen
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                sync1_q[g] <= 1'b0;
                sync2_q[g] <= 1'b0;
            end else begin
                sync1_q[g] <= raw_in[g];
                sync2_q[g] <= sync1_q[g];
            end
        end
    end

    // ---------------------------------------------------------------
    // apb handshake
    // ---------------------------------------------------------------
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic        setup;
    logic        access_done;
    logic        wr_ctrl;
    logic        wr_low;
    logic        rd_high;
    logic        mapped;

    // writes and the done clear land on the access edge, where pready is high
    assign setup       = psel && !penable;
    assign access_done = psel && penable && pready_q;
    assign wr_ctrl     = access_done && pwrite && hits(paddr, `CTRL_INDEX);
    assign wr_low      = access_done && pwrite && hits(paddr, `RES_LOW_INDEX);
    assign rd_high     = access_done && !pwrite && hits(paddr, `RES_HIGH_INDEX);
    // unmapped offsets answer with an error and change nothing
    assign mapped      = hits(paddr, `CTRL_INDEX) || hits(paddr, `RES_HIGH_INDEX)
                         || hits(paddr, `RES_LOW_INDEX);

    // ---------------------------------------------------------------
    // control/status and low byte storage
    // ---------------------------------------------------------------
    logic       done_q, done_d;
    logic       rate_q, rate_d;
    logic       on_q, on_d;
    logic [2:0] chan_q, chan_d;
    logic       slow_q, slow_d;
    logic       restart;
    logic       conv_done;
    logic [7:0] ctrl_view;
    logic [7:0] high_view;
    logic [7:0] low_view;
    logic [`RESULT_BITS-1:0] result;

    // a control write with the on bit set throws away the running conversion
    // like every write it takes effect on the access edge
    assign restart = wr_ctrl && pwdata[`CTRL_ON_BIT];

    // bits 4:3 read as zero and drop whatever is written to them
    assign ctrl_view = {done_q, rate_q, on_q, 2'b00, chan_q};
    assign high_view = result[`RESULT_BITS-1:2];
    assign low_view  = {4'h0, slow_q, 1'b0, result[1:0]};

    // slow sits in the low result byte, the only writable bit there
    always_comb begin
        rate_d = rate_q;
        on_d   = on_q;
        chan_d = chan_q;
        slow_d = slow_q;
        if (wr_ctrl) begin
            rate_d = pwdata[`CTRL_RATE_BIT];
            on_d   = pwdata[`CTRL_ON_BIT];
            chan_d = pwdata[`CTRL_CHAN_MSB:0];
        end
        if (wr_low) begin
            slow_d = pwdata[`LOW_SLOW_BIT];
        end
        // done is never taken from pwdata
        // abort beats a conversion end, and a conversion end beats a high read,
        // so a result that lands during the read is never lost
        if (restart) begin
            done_d = 1'b0;
        end else if (conv_done) begin
            done_d = 1'b1;
        end else if (rd_high) begin
            done_d = 1'b0;
        end else begin
            done_d = done_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'(`CTRL_RESET >> `CTRL_DONE_BIT);
            rate_q <= 1'(`CTRL_RESET >> `CTRL_RATE_BIT);
            on_q   <= 1'(`CTRL_RESET >> `CTRL_ON_BIT);
            chan_q <= 3'(`CTRL_RESET);
            slow_q <= 1'(`LOW_RESET >> `LOW_SLOW_BIT);
        end else begin
            done_q <= done_d;
            rate_q <= rate_d;
            on_q   <= on_d;
            chan_q <= chan_d;
            slow_q <= slow_d;
        end
    end

    // ---------------------------------------------------------------
    // apb response, registered one cycle after setup
    // ---------------------------------------------------------------
    // read data is frozen at setup, so a high read shows the byte as it was
    // before the access edge clears done; the master never waits longer
    always_comb begin
        pready_d  = setup;
        pslverr_d = setup && !mapped;
        prdata_d  = 32'h0000_0000;
        if (setup && !pwrite) begin
            if (hits(paddr, `CTRL_INDEX)) begin
                prdata_d = {24'h00_0000, ctrl_view};
            end else if (hits(paddr, `RES_HIGH_INDEX)) begin
                prdata_d = {24'h00_0000, high_view};
            end else if (hits(paddr, `RES_LOW_INDEX)) begin
                prdata_d = {24'h00_0000, low_view};
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    // response flops drive the bus directly; nothing combinational follows
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign prdata  = prdata_q;

    // ---------------------------------------------------------------
    // converter clock and power
    // ---------------------------------------------------------------
    logic [1:0] div_q, div_d;
    logic       tick;
    logic       run;
    logic       power_q, power_d;
    logic [2:0] chan_out_q, chan_out_d;

    // wait state has no port here, so it cannot stop conversions
    // halt drops run at once but leaves the on bit, so a wake-up resumes
    assign run = on_q && !halt_mode;

    // the divider free-runs while run is high; a restart does not realign it, so the
    // first tick after a control write comes one to four cycles later
    always_comb begin
        div_d = run ? div_q + 2'h1 : 2'h0;
        if (slow_q) begin
            tick = (div_q == `DIV_QUARTER);
        end else if (rate_q) begin
            tick = 1'b1;
        end else begin
            tick = div_q[0];
        end
        // power follows run one cycle late, on the edge the engine idles
        power_d = run;
        // undefined codes park the mux on input zero
        // codes above four still read back as written
        chan_out_d = (chan_q > `CHAN_LAST) ? `CHAN_SAFE : chan_q;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_q      <= 2'h0;
            power_q    <= 1'b0;
            chan_out_q <= `CHAN_SAFE;
        end else begin
            div_q      <= div_d;
            power_q    <= power_d;
            chan_out_q <= chan_out_d;
        end
    end

    assign converter_power      = power_q;
    assign input_channel_select = chan_out_q;

    // ---------------------------------------------------------------
    // sequencer; results overwrite unread ones, nothing interrupts
    // ---------------------------------------------------------------
    // the engine reads only the second synchroniser stage
    sar_engine #(
        .APPROX_CYCLES (APPROX_CYCLES),
        .SAMPLE_TICKS  (SAMPLE_TICKS),
        .RESULT_BITS   (`RESULT_BITS)
    ) u_engine (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .run         (run),
        .restart     (restart),
        .tick        (tick),
        .comp_above  (sync2_q[4]),
        .comp_fine   (sync2_q[3:2]),
        .over_range  (sync2_q[1]),
        .under_range (sync2_q[0]),
        .sample_q    (sample_connect),
        .dac_q       (dac_code),
        .done_q      (conv_done),
        .result_q    (result)
    );

endmodule

// ==== verilog/adc_defs.svh ====
// Purpose: register map, field positions and timing counts of the converter control
// Assumes: 32-bit APB, register byte address is four times its index
// Notes:   definitions only
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// register indices; byte address = index * 4
`define CTRL_INDEX      8'h34
`define RES_HIGH_INDEX  8'h35
`define RES_LOW_INDEX   8'h36

// control/status fields
`define CTRL_DONE_BIT   7
`define CTRL_RATE_BIT   6
`define CTRL_ON_BIT     5
`define CTRL_CHAN_MSB   2
`define CTRL_RESET      8'h00
`define CHAN_LAST       3'h4
`define CHAN_SAFE       3'h0

// low result byte fields
`define LOW_SLOW_BIT    3
`define LOW_RESET       8'h00

// results
`define RESULT_BITS     10
`define RESULT_FULL     10'h3ff
`define RESULT_ZERO     10'h000

// conversion timing, in converter clock ticks
`define APPROX_CYCLES   8
`define SAMPLE_TICKS    4

// converter clock divider tap and synchroniser depth
`define DIV_QUARTER     2'h3
`define SYNC_STAGES     2

`endif

// ==== verilog/adc_pkg.sv ====
// Purpose: shared types of the converter control
// Assumes: nothing
// Notes:   constants live in adc_defs.svh
package adc_pkg;

    typedef enum logic [1:0] {
        st_idle   = 2'b00,
        st_sample = 2'b01,
        st_hold   = 2'b10
    } conv_state_type;

endpackage

// ==== verilog/sar_engine.sv ====
// Purpose: sample/hold sequencer and successive-approximation register
// Assumes: tick is a one-cycle converter clock enable; analog inputs already synchronised
// Notes:   coarse bits by trial, low bits from the fine comparator in the last cycle
`timescale 1ns/10ps
`include "adc_defs.svh"

module sar_engine #(
    parameter int APPROX_CYCLES = `APPROX_CYCLES,
    parameter int SAMPLE_TICKS  = `SAMPLE_TICKS,
    parameter int RESULT_BITS   = `RESULT_BITS
) (
    // clock and reset
    input  wire logic                               sys_clk,
    input  wire logic                               rst,
    // control
    input  wire logic                               run,
    input  wire logic                               restart,
    input  wire logic                               tick,
    // analog front end
    input  wire logic                               comp_above,
    input  wire logic [RESULT_BITS-APPROX_CYCLES-1:0] comp_fine,
    input  wire logic                               over_range,
    input  wire logic                               under_range,
    // outputs
    output logic                                    sample_q,
    output logic [RESULT_BITS-1:0]                  dac_q,
    output logic                                    done_q,
    output logic [RESULT_BITS-1:0]                  result_q
);
    localparam int FINE = RESULT_BITS - APPROX_CYCLES;

    if (APPROX_CYCLES < 1 || APPROX_CYCLES > 15 || FINE < 0 || SAMPLE_TICKS < 1
        || SAMPLE_TICKS > 15) begin
        $error("sar_engine: unsupported timing parameters");
    end

    adc_pkg::conv_state_type  state_q, state_d;
    logic [3:0]               count_q, count_d;
    logic [APPROX_CYCLES-1:0] coarse_q, coarse_d;
    logic                     done_d;
    logic [RESULT_BITS-1:0]   result_d;
    int                       idx;

    always_comb begin
        state_d  = state_q;
        count_d  = count_q;
        coarse_d = coarse_q;
        done_d   = 1'b0;
        result_d = result_q;
        idx      = APPROX_CYCLES - 1 - int'(count_q);
        if (!run) begin
            state_d = adc_pkg::st_idle;
        end else if (restart || state_q == adc_pkg::st_idle) begin
            state_d  = adc_pkg::st_sample;
            count_d  = 4'h0;
            coarse_d = '0;
        end else if (tick) begin
            unique case (state_q)
                adc_pkg::st_sample: begin
                    count_d = count_q + 4'h1;
                    if (count_q == 4'(SAMPLE_TICKS - 1)) begin
                        state_d  = adc_pkg::st_hold;
                        count_d  = 4'h0;
                        coarse_d = '0;
                        coarse_d[APPROX_CYCLES-1] = 1'b1;
                    end
                end
                adc_pkg::st_hold: begin
                    if (!comp_above) begin
                        coarse_d[idx] = 1'b0;
                    end
                    if (idx > 0) begin
                        coarse_d[idx-1] = 1'b1;
                    end
                    count_d = count_q + 4'h1;
                    if (count_q == 4'(APPROX_CYCLES - 1)) begin
                        // back to sampling with no software help
                        state_d = adc_pkg::st_sample;
                        count_d = 4'h0;
                        done_d  = 1'b1;
                        if (over_range) begin
                            result_d = `RESULT_FULL;
                        end else if (under_range) begin
                            result_d = `RESULT_ZERO;
                        end else begin
                            result_d = {coarse_d, comp_fine};
                        end
                    end
                end
                default: begin
                    state_d = adc_pkg::st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q  <= adc_pkg::st_idle;
            count_q  <= 4'h0;
            coarse_q <= '0;
            done_q   <= 1'b0;
            result_q <= `RESULT_ZERO;
            sample_q <= 1'b0;
            dac_q    <= '0;
        end else begin
            state_q  <= state_d;
            count_q  <= count_d;
            coarse_q <= coarse_d;
            done_q   <= done_d;
            result_q <= result_d;
            sample_q <= (state_d == adc_pkg::st_sample);
            dac_q    <= {coarse_d, FINE'(0)};
        end
    end
endmodule

// ==== tb/adc_front_model.sv ====
// Purpose: analog side of the converter: inputs, sample capacitor, comparators
// Assumes: level and range_mode are steady across a conversion
// Notes:   comparators answer at once; the design resynchronises them
`timescale 1ns/10ps

module adc_front_model (
    // clock
    input  wire logic       sys_clk,
    // from the converter
    input  wire logic       sample_connect,
    input  wire logic [9:0] dac_code,
    // test level, range 1 = above, 2 = below
    input  wire logic [9:0] level,
    input  wire logic [1:0] range_mode,
    // comparators
    output logic            comp_above,
    output logic [1:0]      comp_fine,
    output logic            over_range,
    output logic            under_range
);
    logic [9:0] held = 10'h000;

    // capacitor keeps its charge once disconnected
    always @(posedge sys_clk) begin
        if (sample_connect) begin
            held <= level;
        end
    end
    assign comp_above  = held >= dac_code;
    assign comp_fine   = held[1:0];
    assign over_range  = range_mode == 2'h1;
    assign under_range = range_mode == 2'h2;
endmodule

// ==== tb/adc_ctrl_monitor.sv ====
// Purpose: bus and converter checks on the control block ports
// Assumes: sees the top module ports only
// Notes:   bound below the module
`timescale 1ns/10ps
`include "adc_defs.svh"

module adc_ctrl_monitor #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic                    sys_clk,
    input wire logic                    rst,
    // apb
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic [ADDR_W-1:0]       paddr,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    // converter
    input wire logic                    halt_mode,
    input wire logic                    converter_power,
    input wire logic [2:0]              input_channel_select,
    input wire logic                    sample_connect,
    input wire logic [`RESULT_BITS-1:0] dac_code
);
    logic mapped;

    assign mapped = paddr == ADDR_W'(`CTRL_INDEX * 4) || paddr == ADDR_W'(`RES_HIGH_INDEX * 4)
        || paddr == ADDR_W'(`RES_LOW_INDEX * 4);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        pready ##1 !pready;
    endsequence

    ready_once_a: assert property (setup_s |=> answer_s)
        else $error("pready not a single cycle after setup");
    bad_addr_a: assert property (setup_s ##0 !mapped |=> pready && pslverr)
        else $error("unmapped access without error");
    good_addr_a: assert property (setup_s ##0 mapped |=> !pslverr)
        else $error("mapped access flagged as error");
    err_data_a: assert property (pslverr |-> prdata == 32'h0)
        else $error("error response with data");
    byte_wide_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data beyond eight bits");
    halt_off_a: assert property ($past(halt_mode) |-> !converter_power)
        else $error("converter powered in halt");
    chan_range_a: assert property (input_channel_select <= `CHAN_LAST)
        else $error("undefined channel driven");
    coarse_trial_a: assert property (dac_code[1:0] == 2'b00)
        else $error("trial code low bits set");
    mid_start_a: assert property ($fell(sample_connect) && converter_power
        |-> dac_code == 10'h200) else $error("first trial not at mid scale");
    off_idle_a: assert property (!converter_power [*4] |-> !sample_connect)
        else $error("sampling while powered down");
    sample_c: cover property ($rose(sample_connect));
endmodule

bind sar_adc_control adc_ctrl_monitor #(.ADDR_W(ADDR_W)) i_monitor (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode),
    .converter_power(converter_power), .input_channel_select(input_channel_select),
    .sample_connect(sample_connect), .dac_code(dac_code));

// ==== tb/sar_adc_control_tb.sv ====
// Purpose: self-checking bench of the converter control over apb
// Assumes: front model answers comparisons at once
// Notes:   values are checked in slow mode so synchronisers settle
`timescale 1ns/10ps
`include "adc_defs.svh"

module sar_adc_control_tb;
    localparam logic [11:0] A_CTRL = 12'(`CTRL_INDEX * 4);
    localparam logic [11:0] A_HIGH = 12'(`RES_HIGH_INDEX * 4);
    localparam logic [11:0] A_LOW  = 12'(`RES_LOW_INDEX * 4);
    logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, halt_mode;
    logic        comp_above, over_range, under_range, converter_power, sample_connect;
    logic        last_sample = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  comp_fine, range_mode;
    logic [2:0]  input_channel_select;
    logic [9:0]  dac_code, level;
    int          bad_count, num_checks;
    int          cycles = 0;

    sar_adc_control i_dut (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .halt_mode(halt_mode), .comp_above(comp_above),
        .comp_fine(comp_fine), .over_range(over_range), .under_range(under_range),
        .converter_power(converter_power), .input_channel_select(input_channel_select),
        .sample_connect(sample_connect), .dac_code(dac_code));
    adc_front_model i_front (
        .sys_clk(sys_clk), .sample_connect(sample_connect), .dac_code(dac_code),
        .level(level), .range_mode(range_mode), .comp_above(comp_above),
        .comp_fine(comp_fine), .over_range(over_range), .under_range(under_range));

    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;

    task give_verdict;
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // hang guard, far above the length of the sequence
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        last_sample <= sample_connect;
        if (cycles == 30000) begin
            bad_count++;
            give_verdict;
        end
    end

    task check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [7:0] wd,
             output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        // only the bench timeout ends this wait
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task wr_reg(input logic [11:0] a, input logic [7:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, wd, rd, err);
    endtask

    task rd_reg(input logic [11:0] a, output logic [31:0] rd);
        logic err;
        apb(1'b0, a, 8'h00, rd, err);
    endtask

    task wait_done;
        logic [31:0] d;
        int          n;
        d = 0;
        n = 0;
        while (d[7] !== 1'b1 && n < 100) begin
            rd_reg(A_CTRL, d);
            n++;
        end
        check(d[7] === 1'b1, "done flag never set");
    endtask

    task next_rise(output int t);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!(sample_connect === 1'b1 && last_sample === 1'b0) && n < 500);
        t = cycles;
    endtask

    function automatic int exp_div(input logic slow, input logic rate);
        return slow ? 4 : (rate ? 1 : 2);
    endfunction

    function automatic logic [9:0] exp_result(input logic [1:0] m, input logic [9:0] v);
        return m == 2'h1 ? `RESULT_FULL : (m == 2'h2 ? `RESULT_ZERO : v);
    endfunction

    initial begin
        logic [31:0] d;
        logic        err;
        logic [9:0]  e;
        logic [1:0]  m;
        int          t0, t1;
        {rst, psel, penable, pwrite, halt_mode} = 5'b10000;
        {paddr, pwdata, level, range_mode} = '0;
        {bad_count, num_checks} = '0;
        void'($urandom(32'h7d53));
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd_reg(A_CTRL, d);
        check(d === 32'h0, "control not clear after reset");
        rd_reg(A_HIGH, d);
        check(d === 32'h0, "high byte not clear after reset");
        rd_reg(A_LOW, d);
        check(d === 32'h0, "low byte not clear after reset");
        apb(1'b1, 12'h010, 8'hff, d, err);
        check(err === 1'b1, "unmapped write accepted");
        for (int c = 0; c < 8; c++) begin
            wr_reg(A_CTRL, 8'he0 | 8'(c));
            repeat (2) @(posedge sys_clk);
            check(input_channel_select === (c < 5 ? 3'(c) : 3'h0), "channel");
            check(converter_power === 1'b1, "converter not powered");
            rd_reg(A_CTRL, d);
            check(d[7:0] === (8'h60 | 8'(c)), "control readback or done");
        end
        wr_reg(A_LOW, 8'h08);
        for (int i = 0; i < 6; i++) begin
            m = i < 3 ? 2'(i) : 2'h0;
            level <= 10'($urandom);
            range_mode <= m;
            @(posedge sys_clk);
            e = exp_result(m, level);
            wr_reg(A_CTRL, 8'h20 | 8'($urandom_range(4, 0)));
            wait_done;
            rd_reg(A_LOW, d);
            check(d === {24'h0, 6'h02, e[1:0]}, "low byte");
            rd_reg(A_CTRL, d);
            check(d[7] === 1'b1, "low read cleared done");
            rd_reg(A_HIGH, d);
            check(d === {24'h0, e[9:2]}, "high byte");
            rd_reg(A_CTRL, d);
            check(d[7] === 1'b0, "high read left done set");
        end
        // eight-bit use: poll, then read only the high byte
        wait_done;
        rd_reg(A_HIGH, d);
        check(d === {24'h0, e[9:2]}, "high byte alone");
        rd_reg(A_CTRL, d);
        check(d[7] === 1'b0, "high read alone left done set");
        for (int k = 0; k < 3; k++) begin
            wr_reg(A_LOW, k == 2 ? 8'h08 : 8'h00);
            wr_reg(A_CTRL, k == 1 ? 8'h60 : 8'h20);
            next_rise(t0);
            next_rise(t0);
            next_rise(t1);
            check(t1 - t0 == (`SAMPLE_TICKS + `APPROX_CYCLES) * exp_div(k == 2, k == 1),
                  "conversion period");
        end
        halt_mode <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check(converter_power === 1'b0 && sample_connect === 1'b0, "runs in halt");
        halt_mode <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check(converter_power === 1'b1, "no restart after halt");
        wr_reg(A_CTRL, 8'h00);
        rd_reg(A_HIGH, d);
        repeat (60) @(posedge sys_clk);
        check(converter_power === 1'b0, "still powered");
        rd_reg(A_CTRL, d);
        check(d[7] === 1'b0, "conversion after switch off");
        give_verdict;
    end
endmodule
